// *** include/dbg_cmp_pkg.sv ***
// Constants, types and register map of the debug bus comparator configuration block
//
// Contract
// RQ1: Mask bit zero excludes data bit, one includes
// RQ2: Mask bytes at four addresses, most significant lowest
// RQ3: Registers readable always, writable only when disarmed
// RQ4: Control bit 5 selects program counter compare
// RQ5: Bit 3 picks write or read direction
// RQ6: Bit 2 turns direction qualification on
// RQ7: Qualified match needs bus direction equal selection
// RQ8: Instruction select matches program address, data ignored
// RQ9: Control bit 0 enables comparator, disabled never matches
// RQ10: Pair AB range mode uses comparator A control
// RQ11: Pair CD range mode uses comparator C control
// RQ12: Address bits compare bus bits against zero/one
// RQ13: D address three bytes high mid low, reset zero
// RQ14: Data compare bit used only when mask set
// RQ15: Writes while armed are dropped without effect
`default_nettype none
package dbg_cmp_pkg;
	// Basic types
	typedef logic [7:0] byte_t;            // One register byte
	typedef logic [9:0] reg_index_t;       // Register index (byte address / 4)
	typedef logic [3:0] slot_t;            // Storage slot number

	// Widths of the watched buses
	localparam int unsigned CMP_ADDR_W = 24;  // Core address and program counter
	localparam int unsigned CMP_DATA_W = 32;  // Core data bus

	// Register indices; byte address on the bus is four times the index
	localparam reg_index_t IDX_MASK0   = 10'h11c;  // Data mask bits 31..24
	localparam reg_index_t IDX_MASK1   = 10'h11d;  // Data mask bits 23..16
	localparam reg_index_t IDX_MASK2   = 10'h11e;  // Data mask bits 15..8
	localparam reg_index_t IDX_MASK3   = 10'h11f;  // Data mask bits 7..0
	localparam reg_index_t IDX_BCTL    = 10'h120;  // Comparator B control
	localparam reg_index_t IDX_BADDR_H = 10'h125;  // Comparator B address 23..16
	localparam reg_index_t IDX_BADDR_M = 10'h126;  // Comparator B address 15..8
	localparam reg_index_t IDX_BADDR_L = 10'h127;  // Comparator B address 7..0
	localparam reg_index_t IDX_DCTL    = 10'h140;  // Comparator D control
	localparam reg_index_t IDX_DADDR_H = 10'h145;  // Comparator D address 23..16
	localparam reg_index_t IDX_DADDR_M = 10'h146;  // Comparator D address 15..8
	localparam reg_index_t IDX_DADDR_L = 10'h147;  // Comparator D address 7..0
	localparam reg_index_t IDX_RANGE   = 10'h150;  // Pair range selection

	// Storage slots
	localparam int unsigned NUM_SLOTS = 13;     // Number of stored bytes
	localparam slot_t SLOT_MASK0   = 4'h0;
	localparam slot_t SLOT_MASK1   = 4'h1;
	localparam slot_t SLOT_MASK2   = 4'h2;
	localparam slot_t SLOT_MASK3   = 4'h3;
	localparam slot_t SLOT_BCTL    = 4'h4;
	localparam slot_t SLOT_BADDR_H = 4'h5;
	localparam slot_t SLOT_BADDR_M = 4'h6;
	localparam slot_t SLOT_BADDR_L = 4'h7;
	localparam slot_t SLOT_DCTL    = 4'h8;
	localparam slot_t SLOT_DADDR_H = 4'h9;
	localparam slot_t SLOT_DADDR_M = 4'ha;
	localparam slot_t SLOT_DADDR_L = 4'hb;
	localparam slot_t SLOT_RANGE   = 4'hc;
	localparam slot_t SLOT_NONE    = 4'hf;      // Unmapped address

	// Control register fields
	localparam int unsigned CTL_INSTRUCTION_SELECT_BIT = 5;   // Instruction select
	localparam int unsigned CTL_RW_BIT   = 3;   // Access direction, 1 = read
	localparam int unsigned CTL_RWE_BIT  = 2;   // Direction qualify enable
	localparam int unsigned CTL_EN_BIT   = 0;   // Comparator enable
	localparam byte_t CTL_WRITE_MASK     = 8'h2d;  // Implemented control bits

	// Range selection fields
	localparam int unsigned RANGE_AB_BIT = 0;   // Pair A/B range mode
	localparam int unsigned RANGE_CD_BIT = 1;   // Pair C/D range mode
	localparam byte_t RANGE_WRITE_MASK   = 8'h03;

	// Values after reset
	localparam byte_t RESET_BYTE = 8'h00;       // Every stored byte
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic       HRESP_OKAY    = 1'b0;

	// Bus transfer phase
	typedef enum logic [1:0] {
		PH_IDLE,       // No data phase pending
		PH_WRITE,      // Write data phase
		PH_READ_WAIT,  // Read data being fetched, one wait state
		PH_READ_OUT    // Read data on the bus
	} bus_phase_t;
endpackage : dbg_cmp_pkg
`default_nettype wire

// *** test/core_model.sv ***
// Behavioural processor core bus driver feeding the comparators
`timescale 1ns/1ps
`default_nettype none
module core_model
	import dbg_cmp_pkg::*;
(
	// Clock and requested bus cycle
	input  wire logic                  clk,
	input  wire logic [CMP_ADDR_W-1:0] req_addr,
	input  wire logic [CMP_DATA_W-1:0] req_data,
	input  wire logic                  req_rd,
	input  wire logic                  req_av,
	// Core buses
	output logic      [CMP_ADDR_W-1:0] core_addr,
	output logic      [CMP_DATA_W-1:0] core_data,
	output logic                       core_rd
);
	import dbg_cmp_pkg::*;
	logic [CMP_ADDR_W-1:0] addr_q = '0;  // Last driven address
	logic [CMP_DATA_W-1:0] data_q = '0;  // Last driven data
	logic                  rd_q   = 1'b0;
	// Idle cycles show the inverse so stale values never look valid
	always @(posedge clk)
	begin
		if (req_av)
		begin
			addr_q <= req_addr;
			data_q <= req_data;
			rd_q   <= req_rd;
		end
	end
	assign core_addr = req_av ? req_addr : ~addr_q;
	assign core_data = req_av ? req_data : ~data_q;
	assign core_rd   = req_av ? req_rd : ~rd_q;
endmodule : core_model
`default_nettype wire

// *** test/debug_bus_comparator_config_properties.sv ***
// Concurrent checks on the ports of the comparator configuration block
`timescale 1ns/1ps
`default_nettype none
module dbg_cmp_chk
	import dbg_cmp_pkg::*;
(
	input wire logic                  MCLK,
	input wire logic                  ARST_N,
	input wire logic                  CE,
	input wire logic                  HSEL,
	input wire logic [1:0]            HTRANS,
	input wire logic                  HWRITE,
	input wire logic                  HREADY,
	input wire logic                  HREADYOUT,
	input wire logic                  HRESP,
	input wire logic                  ARMED,
	input wire logic [7:0]            A_CONTROL,
	input wire logic [7:0]            C_CONTROL,
	input wire logic [CMP_DATA_W-1:0] A_DATA_VALUE,
	input wire logic [CMP_DATA_W-1:0] CORE_DATA,
	input wire logic                  CORE_IS_READ,
	input wire logic                  CORE_ACCESS_VALID,
	input wire logic                  CORE_PC_VALID,
	input wire logic [CMP_DATA_W-1:0] DATA_MASK,
	input wire logic                  RANGE_AB,
	input wire logic                  RANGE_CD,
	input wire logic                  MATCH_B,
	input wire logic                  MATCH_D,
	input wire logic                  DATA_MASK_MATCH
);
	import dbg_cmp_pkg::*;
	logic wr_ph_q;  // Write data phase in progress
	wire  taken = HSEL && HTRANS[1] && HREADY && CE;  // Address phase accepted
	wire  dm_eq = ((CORE_DATA ^ A_DATA_VALUE) & DATA_MASK) == 32'h0000_0000;
	// Track the write data phase so the armed state can be judged there
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N) wr_ph_q <= 1'b0;
		else if (CE && HREADY) wr_ph_q <= taken && HWRITE;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	sequence s_rd_take; taken && !HWRITE; endsequence
	sequence s_wait_ready; !HREADYOUT ##1 HREADYOUT; endsequence
	property p_rd_wait; s_rd_take |=> s_wait_ready; endproperty
	property p_wr_nowait; taken && HWRITE |=> HREADYOUT; endproperty
	property p_okay; HRESP == HRESP_OKAY; endproperty
	property p_armed_drop; wr_ph_q && ARMED |=> $stable(DATA_MASK) && $stable(RANGE_AB); endproperty
	property p_mask_hit; CORE_ACCESS_VALID && dm_eq |=> DATA_MASK_MATCH; endproperty
	property p_mask_miss; !(CORE_ACCESS_VALID && dm_eq) |=> !DATA_MASK_MATCH; endproperty
	property p_b_off; RANGE_AB && !A_CONTROL[0] |=> !MATCH_B; endproperty
	property p_d_off; RANGE_CD && !C_CONTROL[0] |=> !MATCH_D; endproperty
	property p_b_dir;
		RANGE_AB && !A_CONTROL[5] && A_CONTROL[2] && (A_CONTROL[3] != CORE_IS_READ) |=> !MATCH_B;
	endproperty
	property p_d_instruction_select; RANGE_CD && C_CONTROL[5] && !CORE_PC_VALID |=> !MATCH_D; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	a_okay: assert property (p_okay) else $error("response not okay");
	a_armed_drop: assert property (p_armed_drop) else $error("armed write took effect");
	a_mask_hit: assert property (p_mask_hit) else $error("masked data match missing");
	a_mask_miss: assert property (p_mask_miss) else $error("masked data match spurious");
	a_b_off: assert property (p_b_off) else $error("disabled B matched");
	a_d_off: assert property (p_d_off) else $error("disabled D matched");
	a_b_dir: assert property (p_b_dir) else $error("B matched wrong direction");
	a_d_instruction_select: assert property (p_d_instruction_select) else $error("D matched without program counter");
endmodule : dbg_cmp_chk
bind debug_bus_comparator_config dbg_cmp_chk u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .CE(CE),
	.HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .ARMED(ARMED), .A_CONTROL(A_CONTROL), .C_CONTROL(C_CONTROL),
	.A_DATA_VALUE(A_DATA_VALUE), .CORE_DATA(CORE_DATA), .CORE_IS_READ(CORE_IS_READ),
	.CORE_ACCESS_VALID(CORE_ACCESS_VALID), .CORE_PC_VALID(CORE_PC_VALID),
	.DATA_MASK(DATA_MASK), .RANGE_AB(RANGE_AB), .RANGE_CD(RANGE_CD), .MATCH_B(MATCH_B),
	.MATCH_D(MATCH_D), .DATA_MASK_MATCH(DATA_MASK_MATCH));
`default_nettype wire

// *** test/tb_debug_bus_comparator_config.sv ***
// Self-checking bench of the debug bus comparator configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_debug_bus_comparator_config;
	import dbg_cmp_pkg::*;
	logic mclk, arst_n, hsel, hwrite, hrdy, hresp, armed, rab, rcd, mb, md, mm;
	logic r_rd, r_av, r_pv, c_rd, ce;
	logic [1:0]  htrans;
	logic [7:0]  a_ctl, c_ctl, cb, cd;
	logic [23:0] r_addr, r_pc, c_addr;
	logic [31:0] haddr, hwdata, hrdata, a_dv, dmask, r_data, c_data, rv, em;
	logic [7:0]  mdl [int];  // Reference copy of register bytes
	int idx [13] = '{10'h11c, 10'h11d, 10'h11e, 10'h11f, 10'h120, 10'h125, 10'h126,
		10'h127, 10'h140, 10'h145, 10'h146, 10'h147, 10'h150};
	int error_cnt, samples_checked, cyc;
	logic [31:0] lf = 32'h4a58;
	core_model u_core (.clk(mclk), .req_addr(r_addr), .req_data(r_data), .req_rd(r_rd),
		.req_av(r_av), .core_addr(c_addr), .core_data(c_data), .core_rd(c_rd));
	debug_bus_comparator_config dut (.MCLK(mclk), .ARST_N(arst_n), .CE(ce), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .ARMED(armed),
		.A_CONTROL(a_ctl), .C_CONTROL(c_ctl), .A_DATA_VALUE(a_dv), .CORE_ADDR(c_addr),
		.CORE_DATA(c_data), .CORE_IS_READ(c_rd), .CORE_ACCESS_VALID(r_av), .CORE_PC(r_pc),
		.CORE_PC_VALID(r_pv), .DATA_MASK(dmask), .RANGE_AB(rab), .RANGE_CD(rcd),
		.MATCH_B(mb), .MATCH_D(md), .DATA_MASK_MATCH(mm));
	// Clock of 10 ns
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic close_out;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	// Cut a hang short
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end
	endtask : chk_val
	task automatic chk_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin error_cnt++; $display("ERROR %s expected %b seen %b", n, e, g); end
	endtask : chk_bit
	task automatic rnd;
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		rv = lf;
	endtask : rnd
	// One AHB single transfer, waiting on ready in both phases
	task automatic bus(input logic w, input int i, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= 32'(i * 4);
		do @(posedge mclk); while (hrdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
	endtask : bus
	task automatic wr(input int i, input logic [7:0] d);
		bus(1'b1, i, {rv[31:8], d});
		if (!armed && mdl.exists(i))
			mdl[i] = d & (i == 10'h150 ? RANGE_WRITE_MASK : (i == 10'h120 || i == 10'h140) ?
				CTL_WRITE_MASK : 8'hff);
	endtask : wr
	task automatic rd(input int i);
		bus(1'b0, i, 32'h0);
		chk_val("register", {24'h0, mdl.exists(i) ? mdl[i] : 8'h00}, hrdata);
		chk_bit("response", HRESP_OKAY, hresp);
	endtask : rd
	function automatic logic hit(logic [7:0] c, logic [23:0] r);
		if (!c[0]) return 1'b0;
		if (c[5]) return r_pv && r_pc == r;
		return r_av && r_addr == r && (!c[2] || c[3] == r_rd);
	endfunction : hit
	initial
	begin
		{hsel, hwrite, armed, r_rd, r_av, r_pv, htrans, a_ctl, c_ctl} = '0;
		{haddr, hwdata, a_dv, r_data, r_addr, r_pc} = '0;
		ce = 1'b1;
		arst_n = 1'b0;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		foreach (idx[k]) mdl[idx[k]] = 8'h00;
		foreach (idx[k]) rd(idx[k]);
		rd(10'h121);
		// Fill disarmed, then try again armed
		for (int a = 0; a < 2; a++)
		begin
			armed <= a[0];
			foreach (idx[k]) begin rnd(); wr(idx[k], rv[7:0]); end
			foreach (idx[k]) rd(idx[k]);
			chk_val("data mask", {mdl[10'h11c], mdl[10'h11d], mdl[10'h11e], mdl[10'h11f]}, dmask);
			chk_bit("range ab", mdl[10'h150][0], rab);
			chk_bit("range cd", mdl[10'h150][1], rcd);
		end
		armed <= 1'b0;
		// Clock enable low freezes the registers, so this write must not land
		ce <= 1'b0;
		bus(1'b1, 10'h11c, ~{24'h0, mdl[10'h11c]});
		ce <= 1'b1;
		rd(10'h11c);
		repeat (150)
		begin
			rnd();
			a_ctl <= rv[7:0] & CTL_WRITE_MASK;
			c_ctl <= rv[15:8] & CTL_WRITE_MASK;
			a_dv <= {rv[23:16], rv[7:0], rv[31:16]};
			foreach (idx[k]) begin rnd(); wr(idx[k], rv[7:0] & {8{rv[9]}}); end
			repeat (4)
			begin
				rnd();
				r_av <= rv[0];
				r_pv <= rv[1];
				r_rd <= rv[2];
				r_addr <= rv[3] ? {mdl[10'h125], mdl[10'h126], mdl[10'h127]} :
					rv[4] ? {mdl[10'h145], mdl[10'h146], mdl[10'h147]} : rv[31:8];
				r_pc <= rv[5] ? {mdl[10'h125], mdl[10'h126], mdl[10'h127]} :
					{mdl[10'h145], mdl[10'h146], mdl[10'h147]};
				r_data <= rv[6] ? a_dv : {rv[15:0], rv[31:16]};
				@(posedge mclk);
				#1;
				cb = mdl[10'h150][0] ? a_ctl : mdl[10'h120];
				cd = mdl[10'h150][1] ? c_ctl : mdl[10'h140];
				em = {mdl[10'h11c], mdl[10'h11d], mdl[10'h11e], mdl[10'h11f]};
				chk_bit("match b", hit(cb, {mdl[10'h125], mdl[10'h126], mdl[10'h127]}), mb);
				chk_bit("match d", hit(cd, {mdl[10'h145], mdl[10'h146], mdl[10'h147]}), md);
				chk_bit("data match", r_av && ((r_data ^ a_dv) & em) == 32'h0, mm);
			end
		end
		close_out();
	end
endmodule : tb_debug_bus_comparator_config
`default_nettype wire

// *** verilog/cmp_match.sv ***
// Match qualification of one address comparator
`timescale 1ns/1ps
`default_nettype none
module cmp_match
	import dbg_cmp_pkg::*;
(
	// Effective settings
	input  wire logic [7:0]            ctl,
	input  wire logic [CMP_ADDR_W-1:0] ref_addr,
	// Core data access
	input  wire logic [CMP_ADDR_W-1:0] bus_addr,
	input  wire logic                  bus_is_read,
	input  wire logic                  bus_valid,
	// Core instruction reaching execution
	input  wire logic [CMP_ADDR_W-1:0] pc_addr,
	input  wire logic                  pc_valid,
	// Result
	output logic                       hit
);
	// Decoded control fields
	wire logic enabled   = ctl[CTL_EN_BIT];
	wire logic instruction_select_sel  = ctl[CTL_INSTRUCTION_SELECT_BIT];
	wire logic dir_qual  = ctl[CTL_RWE_BIT];
	wire logic dir_read  = ctl[CTL_RW_BIT];

	// Each reference bit is the level its bus bit must show
	wire logic addr_eq   = (bus_addr == ref_addr);  // RQ12
	wire logic pc_eq     = (pc_addr == ref_addr);   // RQ12

	// Direction check only when qualification is on
	wire logic dir_ok    = !dir_qual || (dir_read == bus_is_read);  // RQ5 RQ6 RQ7

	// Data access match, direction bits ignored under instruction select
	wire logic data_hit  = bus_valid && addr_eq && dir_ok;

	// Program address match is data independent
	wire logic pc_hit    = pc_valid && pc_eq;  // RQ8

	// Disabled comparator never matches
	assign hit = enabled && (instruction_select_sel ? pc_hit : data_hit);  // RQ4 RQ9
endmodule : cmp_match
`default_nettype wire

// *** verilog/debug_bus_comparator_config.sv ***
// Debug bus comparator configuration registers and match qualification
`timescale 1ns/1ps
`default_nettype none
module debug_bus_comparator_config
	import dbg_cmp_pkg::*;
(
	// Clock, reset and clock enable
	input  wire logic                  MCLK,
	input  wire logic                  ARST_N,
	input  wire logic                  CE,
	// AHB-Lite slave port
	input  wire logic                  HSEL,
	input  wire logic [31:0]           HADDR,
	input  wire logic [1:0]            HTRANS,
	input  wire logic                  HWRITE,
	input  wire logic [2:0]            HSIZE,
	input  wire logic [31:0]           HWDATA,
	input  wire logic                  HREADY,
	output logic                       HREADYOUT,
	output logic                       HRESP,
	output logic [31:0]                HRDATA,
	// Debug module state
	input  wire logic                  ARMED,
	// Settings held by neighbouring comparators
	input  wire logic [7:0]            A_CONTROL,
	input  wire logic [7:0]            C_CONTROL,
	input  wire logic [CMP_DATA_W-1:0] A_DATA_VALUE,
	// Core buses
	input  wire logic [CMP_ADDR_W-1:0] CORE_ADDR,
	input  wire logic [CMP_DATA_W-1:0] CORE_DATA,
	input  wire logic                  CORE_IS_READ,
	input  wire logic                  CORE_ACCESS_VALID,
	input  wire logic [CMP_ADDR_W-1:0] CORE_PC,
	input  wire logic                  CORE_PC_VALID,
	// Configuration seen by the rest of the debug module
	output logic [CMP_DATA_W-1:0]      DATA_MASK,
	output logic                       RANGE_AB,
	output logic                       RANGE_CD,
	// Match results
	output logic                       MATCH_B,
	output logic                       MATCH_D,
	output logic                       DATA_MASK_MATCH
);

	// Register index to storage slot
	function automatic slot_t slot_of(input reg_index_t idx);
		case (idx)
			IDX_MASK0:   slot_of = SLOT_MASK0;
			IDX_MASK1:   slot_of = SLOT_MASK1;
			IDX_MASK2:   slot_of = SLOT_MASK2;
			IDX_MASK3:   slot_of = SLOT_MASK3;
			IDX_BCTL:    slot_of = SLOT_BCTL;
			IDX_BADDR_H: slot_of = SLOT_BADDR_H;
			IDX_BADDR_M: slot_of = SLOT_BADDR_M;
			IDX_BADDR_L: slot_of = SLOT_BADDR_L;
			IDX_DCTL:    slot_of = SLOT_DCTL;
			IDX_DADDR_H: slot_of = SLOT_DADDR_H;
			IDX_DADDR_M: slot_of = SLOT_DADDR_M;
			IDX_DADDR_L: slot_of = SLOT_DADDR_L;
			IDX_RANGE:   slot_of = SLOT_RANGE;
			default:     slot_of = SLOT_NONE;
		endcase
	endfunction : slot_of

	// Writable bits of each slot; the rest read as zero
	function automatic byte_t wmask_of(input slot_t slot);
		case (slot)
			SLOT_BCTL:  wmask_of = CTL_WRITE_MASK;
			SLOT_DCTL:  wmask_of = CTL_WRITE_MASK;
			SLOT_RANGE: wmask_of = RANGE_WRITE_MASK;
			SLOT_NONE:  wmask_of = RESET_BYTE;
			default:    wmask_of = 8'hff;
		endcase
	endfunction : wmask_of

	// Register storage, one byte per slot
	byte_t      regs_q [NUM_SLOTS];        // Configuration bytes
	bus_phase_t phase_q;                   // Current data phase
	bus_phase_t phase_d;                   // Next data phase
	slot_t      slot_q;                    // Slot of the pending data phase
	logic [31:0] hrdata_q;                 // Read data register
	logic       match_b_q;                 // Registered comparator B match
	logic       match_d_q;                 // Registered comparator D match
	logic       data_match_q;              // Registered masked data match

	// Address phase decode
	wire logic   addr_take  = HSEL && HTRANS[1] && HREADY;
	wire reg_index_t addr_idx = HADDR[11:2];
	wire slot_t  addr_slot  = slot_of(addr_idx);

	// Data phase write; armed state blocks it completely
	wire logic   wr_slot_ok = (slot_q != SLOT_NONE);
	wire logic   wr_en      = (phase_q == PH_WRITE) && wr_slot_ok && !ARMED;  // RQ3 RQ15
	wire byte_t  wr_mask    = wmask_of(slot_q);
	wire byte_t  wr_byte    = HWDATA[7:0] & wr_mask;

	// Read selection, allowed in any state
	wire logic   rd_slot_ok = (slot_q != SLOT_NONE);
	wire byte_t  rd_byte    = rd_slot_ok ? regs_q[slot_q] : RESET_BYTE;  // RQ3
	wire logic   rd_load    = (phase_q == PH_READ_WAIT);

	// Assembled configuration values
	wire logic [CMP_DATA_W-1:0] data_mask =
		{regs_q[SLOT_MASK0], regs_q[SLOT_MASK1],
		 regs_q[SLOT_MASK2], regs_q[SLOT_MASK3]};  // RQ2
	wire logic [CMP_ADDR_W-1:0] b_addr =
		{regs_q[SLOT_BADDR_H], regs_q[SLOT_BADDR_M], regs_q[SLOT_BADDR_L]};
	wire logic [CMP_ADDR_W-1:0] d_addr =
		{regs_q[SLOT_DADDR_H], regs_q[SLOT_DADDR_M], regs_q[SLOT_DADDR_L]};  // RQ13
	wire byte_t  b_ctl    = regs_q[SLOT_BCTL];
	wire byte_t  d_ctl    = regs_q[SLOT_DCTL];
	wire logic   range_ab = regs_q[SLOT_RANGE][RANGE_AB_BIT];
	wire logic   range_cd = regs_q[SLOT_RANGE][RANGE_CD_BIT];

	// In range mode the lower comparator of a pair takes over the control
	wire byte_t  eff_b_ctl = range_ab ? A_CONTROL : b_ctl;  // RQ10
	wire byte_t  eff_d_ctl = range_cd ? C_CONTROL : d_ctl;  // RQ11

	// Masked data compare: only mask-enabled bits take part
	wire logic [CMP_DATA_W-1:0] data_diff = (CORE_DATA ^ A_DATA_VALUE) & data_mask;  // RQ1 RQ14
	wire logic   data_hit = CORE_ACCESS_VALID && (data_diff == '0);  // RQ1 RQ14

	// Comparator hits
	logic hit_b;                           // Comparator B raw hit
	logic hit_d;                           // Comparator D raw hit

	// Comparator B qualification
	cmp_match u_match_b (
		.ctl         (eff_b_ctl),
		.ref_addr    (b_addr),
		.bus_addr    (CORE_ADDR),
		.bus_is_read (CORE_IS_READ),
		.bus_valid   (CORE_ACCESS_VALID),
		.pc_addr     (CORE_PC),
		.pc_valid    (CORE_PC_VALID),
		.hit         (hit_b)
	);

	// Comparator D qualification
	cmp_match u_match_d (
		.ctl         (eff_d_ctl),
		.ref_addr    (d_addr),
		.bus_addr    (CORE_ADDR),
		.bus_is_read (CORE_IS_READ),
		.bus_valid   (CORE_ACCESS_VALID),
		.pc_addr     (CORE_PC),
		.pc_valid    (CORE_PC_VALID),
		.hit         (hit_d)
	);

	// Next data phase
	always_comb
	begin
		phase_d = phase_q;
		case (phase_q)
			// Read needs one wait state to load the data register
			PH_READ_WAIT:
				phase_d = PH_READ_OUT;
			// Idle, write and read-out phases may take a new transfer
			PH_IDLE, PH_WRITE, PH_READ_OUT:
			begin
				if (addr_take)
					phase_d = HWRITE ? PH_WRITE : PH_READ_WAIT;
				else
					phase_d = PH_IDLE;
			end
			default:
				phase_d = PH_IDLE;
		endcase
	end

	// Phase and slot of the pending transfer
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			phase_q <= PH_IDLE;
			slot_q  <= SLOT_NONE;
		end
		else if (CE)
		begin
			phase_q <= phase_d;
			// Slot follows each accepted address phase
			if (addr_take && (phase_q != PH_READ_WAIT))
				slot_q <= addr_slot;
		end
	end

	// Configuration bytes, written only while disarmed
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
				regs_q[i] <= RESET_BYTE;  // RQ13
		end
		else if (CE && wr_en)
		begin
			regs_q[slot_q] <= wr_byte;  // RQ2 RQ3
		end
	end

	// Read data register, loaded in the wait state
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			hrdata_q <= RESET_WORD;
		else if (CE && rd_load)
			hrdata_q <= {24'h00_0000, rd_byte};
	end

	// Registered match results
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			match_b_q    <= 1'b0;
			match_d_q    <= 1'b0;
			data_match_q <= 1'b0;
		end
		else if (CE)
		begin
			match_b_q    <= hit_b;  // RQ9
			match_d_q    <= hit_d;  // RQ9
			data_match_q <= data_hit;  // RQ14
		end
	end

	// Bus answer: one wait state on reads, none on writes
	assign HREADYOUT = (phase_q != PH_READ_WAIT);
	assign HRESP     = HRESP_OKAY;
	assign HRDATA    = hrdata_q;

	// Configuration outputs straight from the registers
	assign DATA_MASK = data_mask;
	assign RANGE_AB  = range_ab;
	assign RANGE_CD  = range_cd;

	// Match outputs
	assign MATCH_B         = match_b_q;
	assign MATCH_D         = match_d_q;
	assign DATA_MASK_MATCH = data_match_q;

endmodule : debug_bus_comparator_config
`default_nettype wire
